// ==== logic/gpib_device.sv ====
`timescale 1ns/1ps
`include "gpib_defines.svh"
module gpib_device (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  gpib_if.dev             bus,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_eoi,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_eoi,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  input  wire logic [7:0] i_stb,
  input  wire logic       i_rsv,
  input  wire logic       i_ist,
  input  wire logic       i_rtl,
  output logic            o_listen,
  output logic            o_talk,
  output logic            o_remote,
  output logic            o_lockout,
  output logic            o_srq,
  output logic            o_clear,
  output logic            o_trigger
);
  import gpib_pkg::*;

  localparam int SETTLE = `SETTLE_CYC;
  if (SETTLE < 1 || SETTLE > 15) begin : g_chk
    $error("settle count out of range");
  end

  typedef struct packed {
    ah_t        ah;
    sh_t        sh;
    logic [3:0] cnt;
    logic [7:0] rxd;
    logic       rxv;
    logic       rxe;
    logic [7:0] shd;
    logic       she;
    logic       lad;
    logic       tad;
    logic       spms;
    logic       pacs;
    logic       rem;
    logic       llo;
    logic       srq;
    logic       rsv;
    logic       ppen;
    logic       ppsense;
    logic [2:0] ppline;
    logic       clr;
    logic       trg;
  } dev_st_t;

  localparam dev_st_t RST = '{ah: AH_IDLE, sh: SH_IDLE, default: '0};

  dev_st_t q;
  dev_st_t d;
  bus_t    asrt;
  bus_t    oe;
  logic    acc_on;
  logic    rx_busy;
  logic    tx_go;

  ////////////////////////////////////////////////////////////////////////////
  // negative-logic bus seen as asserted-high
  assign asrt       = ~bus.line;
  assign acc_on     = asrt.atn | q.lad;
  // data bytes stall on a full receive register; commands never do
  assign rx_busy    = ~asrt.atn & q.rxv;
  assign tx_go      = q.tad & ~asrt.atn & ~asrt.ifc;
  assign o_tx_ready = tx_go & ~q.spms & (q.sh == SH_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [6:0] cmd;
    logic [7:0] stb;
    cmd = asrt.dio[6:0];
    stb = i_stb;
    stb[`STB_RQS_BIT] = q.srq;
    d = q;
    d.clr = 1'b0;
    d.trg = 1'b0;
    d.rsv = i_rsv;
    if (i_rx_ready && q.rxv) begin
      d.rxv = 1'b0;
    end
    // return to local first, so an own listen address in the same
    // cycle still wins
    if (i_rtl && !q.llo) begin
      d.rem = 1'b0;
    end
    // acceptor
    case (q.ah)
      AH_IDLE: begin
        if (acc_on) begin
          d.ah = AH_READY;
        end
      end
      AH_READY: begin
        if (!acc_on) begin
          d.ah = AH_IDLE;
        end else if (asrt.dav && !rx_busy) begin
          d.ah = AH_WAIT;
          if (asrt.atn) begin
            if (cmd[6:5] != `GRP_SEC) begin
              d.pacs = 1'b0;
            end
            case (cmd[6:5])
              `GRP_LISTEN: begin
                if (cmd[4:0] == i_addr) begin
                  d.lad = 1'b1;
                  d.tad = 1'b0;
                  if (asrt.ren) begin
                    d.rem = 1'b1;
                  end
                end else if (cmd[4:0] == `ADDR_NONE) begin
                  d.lad = 1'b0;
                end
              end
              `GRP_TALK: begin
                if (cmd[4:0] == i_addr) begin
                  d.tad = 1'b1;
                  d.lad = 1'b0;
                end else begin
                  d.tad = 1'b0;
                end
              end
              `GRP_SEC: begin
                if (q.pacs) begin
                  d.ppen    = ~cmd[4];
                  d.ppsense = cmd[3];
                  d.ppline  = cmd[2:0];
                end
              end
              default: begin
                if (cmd == `CMD_GTL && q.lad) begin
                  d.rem = 1'b0;
                end
                if (cmd == `CMD_DCL || (cmd == `CMD_SDC && q.lad)) begin
                  d.clr = 1'b1;
                end
                if (cmd == `CMD_GET && q.lad) begin
                  d.trg = 1'b1;
                end
                if (cmd == `CMD_LLO) begin
                  d.llo = 1'b1;
                end
                if (cmd == `CMD_PPU) begin
                  d.ppen = 1'b0;
                end
                if (cmd == `CMD_PPC && q.lad) begin
                  d.pacs = 1'b1;
                end
                if (cmd == `CMD_SPE) begin
                  d.spms = 1'b1;
                end
                if (cmd == `CMD_SPD) begin
                  d.spms = 1'b0;
                end
              end
            endcase
          end else begin
            d.rxd = asrt.dio;
            d.rxe = asrt.eoi;
            d.rxv = 1'b1;
          end
        end
      end
      AH_WAIT: begin
        if (!asrt.dav) begin
          d.ah = acc_on ? AH_READY : AH_IDLE;
        end
      end
      default: d.ah = AH_IDLE;
    endcase
    // source
    case (q.sh)
      SH_IDLE: begin
        if (tx_go && (q.spms || i_tx_valid)) begin
          d.shd = q.spms ? stb : i_tx_data;
          d.she = q.spms ? 1'b0 : i_tx_eoi;
          d.cnt = 4'(SETTLE);
          d.sh  = SH_GEN;
          if (q.spms) begin
            d.srq = 1'b0;
          end
        end
      end
      SH_GEN: begin
        if (!tx_go) begin
          d.sh = SH_IDLE;
        end else if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else if (!asrt.nrfd && asrt.ndac) begin
          d.sh = SH_TRANS;
        end
      end
      SH_TRANS: begin
        if (!tx_go || !asrt.ndac) begin
          d.sh = SH_IDLE;
        end
      end
      default: d.sh = SH_IDLE;
    endcase
    // service request; a new request wins over the poll clearing it
    if (!i_rsv) begin
      d.srq = 1'b0;
    end else if (!q.rsv) begin
      d.srq = 1'b1;
    end
    // remote/local
    if (!asrt.ren) begin
      d.rem = 1'b0;
      d.llo = 1'b0;
    end
    if (asrt.ifc) begin
      d.lad  = 1'b0;
      d.tad  = 1'b0;
      d.spms = 1'b0;
      d.pacs = 1'b0;
      d.sh   = SH_IDLE;
      d.ah   = AH_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain drive; a limitation: the poll bit can collide with data
  // only if a controller polls mid-transfer, for the one cycle before atn idles the source
  always_comb begin
    oe = '0;
    if (q.sh != SH_IDLE) begin
      oe.dio = q.shd;
      oe.eoi = q.she;
    end
    oe.dav  = (q.sh == SH_TRANS);
    oe.ndac = (q.ah == AH_READY);
    oe.nrfd = (q.ah == AH_WAIT) || (q.ah == AH_READY && rx_busy);
    oe.srq  = q.srq;
    if (asrt.atn && asrt.eoi && q.ppen && (i_ist == q.ppsense)) begin
      oe.dio[q.ppline] = 1'b1;
    end
  end
  assign bus.dev_oe = oe;
  assign bus.dev_o  = '0;

  assign o_rx_data = q.rxd;
  assign o_rx_eoi  = q.rxe;
  assign o_rx_valid = q.rxv;
  assign o_listen  = q.lad;
  assign o_talk    = q.tad;
  assign o_remote  = q.rem;
  assign o_lockout = q.llo;
  assign o_srq     = q.srq;
  assign o_clear   = q.clr;
  assign o_trigger = q.trg;
endmodule

// ==== logic/gpib_defines.svh ====
`ifndef GPIB_DEFINES_SVH
`define GPIB_DEFINES_SVH
`define CLK_MHZ      100
`define T_SETTLE_NS  20
`define SETTLE_CYC   ((`T_SETTLE_NS*`CLK_MHZ+999)/1000)
`define T_IFC_US     100
`define IFC_CYC      (`T_IFC_US*`CLK_MHZ)
`define T_PP_NS      2000
`define PP_CYC       ((`T_PP_NS*`CLK_MHZ+999)/1000)
`define GRP_UNIV     2'h0
`define GRP_LISTEN   2'h1
`define GRP_TALK     2'h2
`define GRP_SEC      2'h3
`define ADDR_NONE    5'h1F
`define CMD_GTL      7'h01
`define CMD_SDC      7'h04
`define CMD_PPC      7'h05
`define CMD_GET      7'h08
`define CMD_LLO      7'h11
`define CMD_DCL      7'h14
`define CMD_PPU      7'h15
`define CMD_SPE      7'h18
`define CMD_SPD      7'h19
`define STB_RQS_BIT  6
`endif

// ==== logic/gpib_pkg.sv ====
package gpib_pkg;
  // one bit per bus line; in oe and asrt 1 = line pulled low (asserted), on line 1 = line high
  typedef struct packed {
    logic [7:0] dio;
    logic       atn;
    logic       eoi;
    logic       srq;
    logic       ifc;
    logic       ren;
    logic       dav;
    logic       nrfd;
    logic       ndac;
  } bus_t;
  typedef enum logic [2:0] {
    AH_IDLE  = 3'h1,
    AH_READY = 3'h2,
    AH_WAIT  = 3'h4
  } ah_t;
  typedef enum logic [2:0] {
    SH_IDLE  = 3'h1,
    SH_GEN   = 3'h2,
    SH_TRANS = 3'h4
  } sh_t;
  typedef enum logic [6:0] {
    C_IDLE  = 7'h01,
    C_IFC   = 7'h02,
    C_GEN   = 7'h04,
    C_DAV   = 7'h08,
    C_ARDY  = 7'h10,
    C_AWAIT = 7'h20,
    C_PP    = 7'h40
  } ctl_st_t;
endpackage

// ==== logic/gpib_if.sv ====
`timescale 1ns/1ps
interface gpib_if;
  import gpib_pkg::*;
  bus_t dev_o;
  bus_t dev_oe;
  bus_t ctl_o;
  bus_t ctl_oe;
  bus_t line;
  // wired-and: a line is low if any enabled party drives low
  assign line = (~dev_oe | dev_o) & (~ctl_oe | ctl_o);
  modport dev (input line, output dev_o, output dev_oe);
  modport ctl (input line, output ctl_o, output ctl_oe);
endinterface

// ==== logic/gpib_controller.sv ====
`timescale 1ns/1ps
`include "gpib_defines.svh"
module gpib_controller #(
  parameter int unsigned IFC_CYC = `IFC_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  gpib_if.ctl             bus,
  input  wire logic       i_cmd_valid,
  input  wire logic       i_cmd_atn,
  input  wire logic [7:0] i_cmd_data,
  input  wire logic       i_cmd_eoi,
  output logic            o_cmd_ready,
  input  wire logic       i_listen,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_eoi,
  output logic            o_rx_valid,
  input  wire logic       i_rx_ready,
  input  wire logic       i_ifc,
  input  wire logic       i_ren,
  input  wire logic       i_pp,
  output logic [7:0]      o_pp_data,
  output logic            o_pp_valid,
  output logic            o_srq
);
  import gpib_pkg::*;

  localparam int SETTLE = `SETTLE_CYC;
  localparam int PPW    = `PP_CYC;
  if (IFC_CYC < 1 || IFC_CYC > 65535 || PPW > 65535) begin : g_chk
    $error("controller count out of range");
  end

  typedef struct packed {
    ctl_st_t     st;
    logic [15:0] cnt;
    logic        atn;
    logic        ren;
    logic        srq;
    logic [7:0]  d;
    logic        e;
    logic [7:0]  rxd;
    logic        rxv;
    logic        rxe;
    logic [7:0]  ppd;
    logic        ppv;
  } ctl_t;

  localparam ctl_t RST = '{st: C_IDLE, default: '0};

  ctl_t q;
  ctl_t n;
  bus_t asrt;
  bus_t oe;

  assign asrt = ~bus.line;
  assign o_cmd_ready = (q.st == C_IDLE) && !i_ifc && !i_pp;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.ppv = 1'b0;
    n.ren = i_ren;
    n.srq = asrt.srq;
    if (i_rx_ready && q.rxv) begin
      n.rxv = 1'b0;
    end
    case (q.st)
      C_IDLE: begin
        if (i_ifc) begin
          n.cnt = 16'(IFC_CYC - 1);
          n.st  = C_IFC;
        end else if (i_pp) begin
          n.atn = 1'b1;
          n.cnt = 16'(PPW);
          n.st  = C_PP;
        end else if (i_cmd_valid) begin
          n.d   = i_cmd_data;
          n.e   = i_cmd_eoi;
          n.atn = i_cmd_atn;
          n.cnt = 16'(SETTLE);
          n.st  = C_GEN;
        end else if (i_listen) begin
          n.atn = 1'b0;
          n.st  = C_ARDY;
        end
      end
      C_IFC: begin
        if (q.cnt == 16'h0) begin
          n.atn = 1'b0;
          n.st  = C_IDLE;
        end else begin
          n.cnt = q.cnt - 16'h1;
        end
      end
      C_PP: begin
        if (q.cnt == 16'h0) begin
          n.ppd = asrt.dio;
          n.ppv = 1'b1;
          n.st  = C_IDLE;
        end else begin
          n.cnt = q.cnt - 16'h1;
        end
      end
      C_GEN: begin
        if (q.cnt != 16'h0) begin
          n.cnt = q.cnt - 16'h1;
        end else if (!asrt.nrfd && asrt.ndac) begin
          n.st = C_DAV;
        end
      end
      C_DAV: begin
        if (!asrt.ndac) begin
          n.st = C_IDLE;
        end
      end
      C_ARDY: begin
        if (!i_listen) begin
          n.st = C_IDLE;
        end else if (asrt.dav && !q.rxv) begin
          n.rxd = asrt.dio;
          n.rxe = asrt.eoi;
          n.rxv = 1'b1;
          n.st  = C_AWAIT;
        end
      end
      C_AWAIT: begin
        if (!asrt.dav) begin
          n.st = C_ARDY;
        end
      end
      default: n.st = C_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // atn stays where the last transfer, poll or interface clear left it, so a command burst holds it
  always_comb begin
    oe = '0;
    if (q.st == C_GEN || q.st == C_DAV) begin
      oe.dio = q.d;
      oe.eoi = q.e;
    end
    oe.eoi  = oe.eoi | (q.st == C_PP);
    oe.atn  = q.atn;
    oe.ifc  = (q.st == C_IFC);
    oe.ren  = q.ren;
    oe.dav  = (q.st == C_DAV);
    oe.ndac = (q.st == C_ARDY);
    oe.nrfd = (q.st == C_AWAIT) || (q.st == C_ARDY && q.rxv);
  end
  assign bus.ctl_oe = oe;
  assign bus.ctl_o  = '0;

  assign o_rx_data  = q.rxd;
  assign o_rx_eoi   = q.rxe;
  assign o_rx_valid = q.rxv;
  assign o_pp_data  = q.ppd;
  assign o_pp_valid = q.ppv;
  assign o_srq      = q.srq;
endmodule

// ==== sim/gpib_asserts.sv ====
`timescale 1ns/1ps
module gpib_asserts (
  input wire logic           i_clk_sys,
  input wire logic           i_rst,
  input wire gpib_pkg::bus_t dev_o,
  input wire gpib_pkg::bus_t dev_oe,
  input wire gpib_pkg::bus_t ctl_o,
  input wire gpib_pkg::bus_t ctl_oe,
  input wire gpib_pkg::bus_t line
);
  import gpib_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  sequence dav_on_s;
    $fell(line.dav);
  endsequence
  sequence dav_held_s;
    !line.dav && $past(!line.dav);
  endsequence
  sequence lines_ok_s;
    $past(line.nrfd) && $past(!line.ndac);
  endsequence
  sequence taken_s;
    $rose(line.ndac) && !line.dav;
  endsequence
  drive_low_a: assert property (dev_o == '0 && ctl_o == '0)
    else $error("line driven high");
  line_owner_a: assert property (
    !dev_oe.atn && !dev_oe.ifc && !dev_oe.ren && !ctl_oe.srq)
    else $error("party pulls a line it does not own");
  data_hold_a: assert property (dav_held_s |-> $stable(line.dio))
    else $error("data moved under dav");
  dav_wait_a: assert property (dav_on_s |-> lines_ok_s)
    else $error("dav without ready");
  dav_drop_a: assert property (
    !line.dav && line.ndac |=> line.dav)
    else $error("dav held after accept");
  // ndac and nrfd swap in one cycle, so no gap lets a new dav in
  ndac_up_a: assert property (taken_s |-> !line.nrfd)
    else $error("ndac released while ready");
  ndac_back_a: assert property (
    $rose(line.dav) && !line.nrfd |=> !line.ndac)
    else $error("ndac not reasserted");
  poll_line_a: assert property (
    !line.atn && !line.eoi |-> $onehot0(dev_oe.dio))
    else $error("poll on several lines");
  atn_quiet_a: assert property (
    !line.atn && $past(!line.atn) && line.eoi
    |-> !dev_oe.dav && dev_oe.dio == 8'h00)
    else $error("device talks under atn");
  ifc_idle_a: assert property (
    !line.ifc && $past(!line.ifc) |-> !dev_oe.dav && dev_oe.dio == 8'h00)
    else $error("source busy in clear");
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "gpib_defines.svh"
module tb;
  import gpib_pkg::*;
  logic       i_clk_sys = 0;
  logic       i_rst     = 1;
  logic [4:0] addr      = 0;
  logic [7:0] t_dat = 0, stb = 0, c_dat = 0, trg_n = 0, clr_n = 0;
  logic       t_eoi = 0, t_val = 0, d_take = 0, rsv = 0, ist = 0;
  logic       c_val = 0, c_atn = 0, c_eoi = 0, c_lis = 0, c_take = 0;
  logic       ifc = 0, ren = 0, pp_go = 0, hold = 0, dav_q = 1, rtl = 0;
  logic       d_txr, d_rxe, d_rxv, lis, tlk, rem, lock, srq_d, clr, trg;
  logic       c_ok, c_rxe, c_rxv, ppv, srq_c;
  logic [7:0] d_rxd, c_rxd, ppd, pp_q;
  logic [8:0] dq[$], cq[$], sq[$];
  logic [7:0] wq[$];
  bus_t       ln;
  int         seed = 32'h854A6AE9;
  int         errors = 0;
  int         compares = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  gpib_if gpib_if_i ();
  assign ln = gpib_if_i.line;
  gpib_device gpib_device_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(gpib_if_i.dev),
    .i_addr(addr), .i_tx_data(t_dat), .i_tx_eoi(t_eoi),
    .i_tx_valid(t_val), .o_tx_ready(d_txr), .o_rx_data(d_rxd),
    .o_rx_eoi(d_rxe), .o_rx_valid(d_rxv), .i_rx_ready(d_take),
    .i_stb(stb), .i_rsv(rsv), .i_ist(ist), .i_rtl(rtl),
    .o_listen(lis), .o_talk(tlk), .o_remote(rem), .o_lockout(lock),
    .o_srq(srq_d), .o_clear(clr), .o_trigger(trg));
  gpib_controller #(.IFC_CYC(4)) gpib_controller_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(gpib_if_i.ctl),
    .i_cmd_valid(c_val), .i_cmd_atn(c_atn), .i_cmd_data(c_dat),
    .i_cmd_eoi(c_eoi), .o_cmd_ready(c_ok), .i_listen(c_lis),
    .o_rx_data(c_rxd), .o_rx_eoi(c_rxe), .o_rx_valid(c_rxv),
    .i_rx_ready(c_take), .i_ifc(ifc), .i_ren(ren), .i_pp(pp_go),
    .o_pp_data(ppd), .o_pp_valid(ppv), .o_srq(srq_c));
  gpib_asserts gpib_asserts_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .dev_o(gpib_if_i.dev_o),
    .dev_oe(gpib_if_i.dev_oe), .ctl_o(gpib_if_i.ctl_o),
    .ctl_oe(gpib_if_i.ctl_oe), .line(gpib_if_i.line));
  ////////////////////////////////////////
  // random consumers make the acceptors stall with a full rx register
  always @(negedge i_clk_sys) begin
    d_take <= 1'($random(seed));
    c_take <= hold ? 1'b0 : 1'($random(seed));
  end
  always @(posedge i_clk_sys) begin
    if (d_rxv && d_take) dq.push_back({d_rxe, d_rxd});
    if (c_rxv && c_take) cq.push_back({c_rxe, c_rxd});
    if (trg) trg_n <= trg_n + 8'h1;
    if (clr) clr_n <= clr_n + 8'h1;
    if (ppv) pp_q <= ppd;
    if (dav_q && !ln.dav) wq.push_back(~ln.dio);
    dav_q <= ln.dav;
  end
  function automatic logic [7:0] lad(input logic [4:0] a);
    return {3'h1, a};
  endfunction
  function automatic logic [7:0] tad(input logic [4:0] a);
    return {3'h2, a};
  endfunction
  function automatic logic [7:0] stb_x(input logic [7:0] s);
    return {s[7], 1'b1, s[5:0]};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_q(input logic [8:0] got[$]);
    chk(24'(got.size()), 24'(sq.size()));
    foreach (sq[i]) begin
      chk(24'(got[i]), 24'(sq[i]));
      chk(24'(wq[i]), 24'(sq[i][7:0]));
    end
  endtask
  task automatic cmd(input logic a, input logic [7:0] d, input logic e);
    @(negedge i_clk_sys);
    {c_val, c_atn, c_dat, c_eoi} = {1'b1, a, d, e};
    for (int n = 0; n < 400 && !c_ok; n++) @(negedge i_clk_sys);
    chk(24'(c_ok), 24'h1);
    @(negedge i_clk_sys);
    c_val = 0;
    for (int n = 0; n < 400 && !c_ok; n++) @(negedge i_clk_sys);
    chk(24'(c_ok), 24'h1);
    repeat (3) @(negedge i_clk_sys);
  endtask
  task automatic dsend(input logic [7:0] d, input logic e);
    @(negedge i_clk_sys);
    {t_val, t_dat, t_eoi} = {1'b1, d, e};
    for (int n = 0; n < 400 && !d_txr; n++) @(negedge i_clk_sys);
    chk(24'(d_txr), 24'h1);
    @(negedge i_clk_sys);
    t_val = 0;
  endtask
  task automatic ppoll(input logic [7:0] exp);
    pp_q = 8'h5A;
    @(negedge i_clk_sys);
    pp_go = 1;
    @(negedge i_clk_sys);
    pp_go = 0;
    repeat (220) @(negedge i_clk_sys);
    chk(24'(pp_q), 24'(exp));
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    final_report;
  end
  initial begin
    logic [7:0] b;
    logic       s;
    logic [2:0] l;
    addr = 5'({$random(seed)} % 31);
    stb = 8'($random(seed));
    repeat (5) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst = 0;
    @(negedge i_clk_sys);
    chk(24'(ln), 24'hFFFF);
    chk({lis, tlk, rem, lock, srq_d, d_txr}, 24'h0);
    cmd(1, lad(addr), 0);
    chk({lis, rem}, 24'h2);
    ren = 1;
    cmd(1, lad(addr), 0);
    chk({lis, rem}, 24'h3);
    wq.delete();
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      sq.push_back({i == 5, b});
      cmd(0, b, i == 5);
    end
    repeat (20) @(negedge i_clk_sys);
    chk_q(dq);
    cmd(1, `CMD_GET, 0);
    cmd(1, `CMD_SDC, 0);
    cmd(1, `CMD_DCL, 0);
    chk({trg_n, clr_n}, 24'h0102);
    cmd(1, 8'h3F, 0);
    cmd(1, `CMD_GET, 0);
    cmd(1, `CMD_SDC, 0);
    cmd(1, `CMD_DCL, 0);
    chk({trg_n, clr_n, 7'h0, lis}, 24'h010300);
    cmd(1, `CMD_LLO, 0);
    rtl = 1;
    repeat (3) @(negedge i_clk_sys);
    rtl = 0;
    chk({rem, lock}, 24'h3);
    cmd(1, lad(addr), 0);
    cmd(1, `CMD_GTL, 0);
    chk({rem, lock}, 24'h1);
    ren = 0;
    repeat (3) @(negedge i_clk_sys);
    chk({rem, lock}, 24'h0);
    ren = 1;
    cmd(1, lad(addr), 0);
    chk(24'(rem), 24'h1);
    rtl = 1;
    @(negedge i_clk_sys);
    rtl = 0;
    chk(24'(rem), 24'h0);
    cmd(1, tad(addr), 0);
    chk({tlk, lis}, 24'h2);
    c_lis = 1;
    sq.delete();
    wq.delete();
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      sq.push_back({i == 3, b});
      dsend(b, i == 3);
    end
    repeat (20) @(negedge i_clk_sys);
    c_lis = 0;
    chk_q(cq);
    cmd(1, lad(addr), 0);
    chk({tlk, lis, rem}, 24'h3);
    rsv = 1;
    repeat (3) @(negedge i_clk_sys);
    chk({srq_d, srq_c, ln.srq}, 24'h6);
    // rx kept full so the poller never takes a second status byte
    hold = 1;
    cmd(1, `CMD_SPE, 0);
    cmd(1, tad(addr), 0);
    c_lis = 1;
    for (int n = 0; n < 400 && !c_rxv; n++) @(negedge i_clk_sys);
    chk(24'(c_rxv), 24'h1);
    chk(24'(c_rxd), 24'(stb_x(stb)));
    c_lis = 0;
    hold = 0;
    cmd(1, `CMD_SPD, 0);
    chk({srq_d, ln.srq}, 24'h1);
    cmd(1, tad(5'h1F), 0);
    chk(24'(tlk), 24'h0);
    rsv = 0;
    s = 1'($random(seed));
    l = 3'($random(seed));
    cmd(1, lad(addr), 0);
    cmd(1, `CMD_PPC, 0);
    cmd(1, {4'h6, s, l}, 0);
    ist = s;
    ppoll(8'h1 << l);
    ist = ~s;
    ppoll(8'h0);
    cmd(1, `CMD_PPU, 0);
    ist = s;
    ppoll(8'h0);
    cmd(1, `CMD_PPC, 0);
    cmd(1, {4'h6, s, l}, 0);
    cmd(1, {4'h7, s, l}, 0);
    ppoll(8'h0);
    @(negedge i_clk_sys);
    ifc = 1;
    @(negedge i_clk_sys);
    ifc = 0;
    repeat (12) @(negedge i_clk_sys);
    chk({lis, tlk, rem}, 24'h1);
    final_report;
  end
endmodule
